// [smt_master.sv]
// spi master: byte engine with four modes and per-slave selects
// Notes on behaviour
// [RULE1] this block is the only bus master
// [RULE2] master drives sclk and slave select
// [RULE3] selected slave answers on miso
// [RULE4] equal bits shifted each direction
// [RULE5] four modes from cpol and cpha
// [RULE6] idle sclk level equals cpol
// [RULE7] cpha picks leading or trailing sample
// [RULE8] sample edge rising modes 0,3
// [RULE9] phase zero slave presents bit early
// [RULE10] phase one slave shifts on lead
// [RULE11] one bit per period, eight per byte
// [RULE12] bytes back to back, optional gap
// [RULE13] transfer ends on lasting deselect
// [RULE14] sclk limited to 5 MHz
// [RULE15] each slave has its own select
// [RULE16] selects active low, idle high
// [RULE17] msb first unless lsb selected
`timescale 1ns/10ps
`default_nettype none
module smt_master
  import smt_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // byte request from user logic
  input wire logic start_i,
  input wire logic last_i,
  input wire logic gap_i,
  input wire logic [7:0] tx_byte_i,
  input wire smt_cfg_s cfg_i,
  // byte answer to user logic
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  // spi pins
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic [NUM_SLAVES-1:0] ss_n_o
);
  smt_state_e state_r;
  smt_cfg_s cfg_r; // latched at start of a transfer
  logic [7:0] tx_r; // outgoing shift register
  logic [7:0] rx_r; // incoming shift register
  logic [3:0] bits_r; // bits completed in this byte
  logic last_r; // deselect after this byte
  logic gap_r; // short deselect after this byte
  logic miso_m_r; // synchroniser first stage
  logic miso_s_r; // synchronised miso
  logic tick;
  logic run;
  logic sample_lead;
  logic [7:0] rx_new;
  logic [7:0] tx_shift; // outgoing byte after one shift
  logic out_bit;

  // divider runs while bits move or a closing deselect is timed
  // held at zero while a chain waits, so a late start still gets a full half period
  assign run = (state_r == SMT_LEAD) || (state_r == SMT_TRAIL) ||
               (state_r == SMT_GAP && (last_r || gap_r));
  smt_tick u_tick (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .run_i(run),
    .half_div_i(cfg_r.half_div),
    .tick_o(tick)
  );

  // miso crosses in from the pin through two flops
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= miso_i;
      miso_s_r <= miso_m_r;
    end
  end

  // [RULE7] [RULE8] sample edge choice
  assign sample_lead = !cfg_r.cpha;
  // [RULE17] shift direction selection
  always_comb begin
    rx_new = cfg_r.lsb_first ? {miso_s_r, rx_r[7:1]} : {rx_r[6:0], miso_s_r};
    tx_shift = cfg_r.lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    out_bit = cfg_r.lsb_first ? tx_r[0] : tx_r[7];
  end

  // sequencing of half periods
  // the synchroniser adds delay, so a slow divider keeps miso sampling safe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= SMT_IDLE;
      cfg_r <= '0;
      tx_r <= BYTE_RST;
      rx_r <= BYTE_RST;
      bits_r <= BITCNT_RST;
      last_r <= 1'b1;
      gap_r <= 1'b0;
      done_o <= 1'b0;
      rx_byte_o <= BYTE_RST;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        // waiting; accept a new byte
        SMT_IDLE: begin
          // [RULE1] only this block starts transfers
          if (start_i) begin
            cfg_r <= cfg_i;
            tx_r <= tx_byte_i;
            last_r <= last_i;
            gap_r <= gap_i;
            bits_r <= BITCNT_RST;
            busy_o <= 1'b1;
            state_r <= SMT_LEAD;
          end
        end
        // first half of a bit, ends with the leading edge
        SMT_LEAD: begin
          if (tick) begin
            // [RULE9] capture early bit on leading edge
            if (sample_lead) begin
              rx_r <= rx_new;
            end
            // [RULE10] phase one moves mosi at leading edge
            // first bit already stands from the start, so no shift then
            if (!sample_lead && bits_r != BITCNT_RST) begin
              tx_r <= tx_shift;
            end
            state_r <= SMT_TRAIL;
          end
        end
        // second half, ends with the trailing edge
        SMT_TRAIL: begin
          if (tick) begin
            // [RULE10] capture on trailing edge
            if (!sample_lead) begin
              rx_r <= rx_new;
            end
            // [RULE4] one out and one in per bit
            // phase zero moves mosi at the trailing edge, clear of its sample edge
            if (sample_lead) begin
              tx_r <= tx_shift;
            end
            bits_r <= bits_r + 4'h1;
            // [RULE11] eight periods per byte
            if (bits_r == 4'(BYTE_BITS - 1)) begin
              done_o <= 1'b1;
              rx_byte_o <= sample_lead ? rx_r : rx_new;
              state_r <= SMT_GAP;
            end else begin
              state_r <= SMT_LEAD;
            end
          end
        end
        // between bytes: chain, short deselect or finish
        SMT_GAP: begin
          // [RULE12] back to back bytes
          if (!last_r && !gap_r && start_i) begin
            tx_r <= tx_byte_i;
            last_r <= last_i;
            gap_r <= gap_i;
            bits_r <= BITCNT_RST;
            state_r <= SMT_LEAD;
          end else if (last_r || gap_r) begin
            if (tick) begin
              // [RULE13] lasting deselect ends transfer
              busy_o <= 1'b0;
              state_r <= SMT_IDLE;
            end
          end
        end
        default: begin
          state_r <= SMT_IDLE;
        end
      endcase
    end
  end

  // pin drivers registered from state
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_o <= 1'b0;
      mosi_o <= 1'b0;
      ss_n_o <= SEL_IDLE;
    end else begin
      // [RULE6] idle level is cpol, [RULE5] mode by cpol/cpha
      // [RULE2] master makes sclk and selects
      if (state_r == SMT_TRAIL) begin
        sclk_o <= ~cfg_r.cpol;
      end else if (state_r == SMT_IDLE && start_i) begin
        // new polarity settles a cycle before the select falls
        sclk_o <= cfg_i.cpol;
      end else begin
        sclk_o <= cfg_r.cpol;
      end
      // phase one shifts out at the leading edge, phase zero before it
      mosi_o <= out_bit;
      // [RULE15] [RULE16] one active low select per slave
      // held through the closing half period so the last trailing edge is seen selected
      if (state_r != SMT_IDLE) begin
        ss_n_o <= SEL_IDLE & ~(NUM_SLAVES'(1) << cfg_r.slave);
      end else begin
        ss_n_o <= SEL_IDLE;
      end
    end
  end

  // checks
  property p_idle_pol;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r == SMT_IDLE) |=> (sclk_o == cfg_r.cpol);
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("sclk idle level wrong"); // [RULE6]
  property p_sel_idle;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r == SMT_IDLE) |=> (ss_n_o == SEL_IDLE);
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select not idle high"); // [RULE16]
  property p_one_sel;
    @(posedge mclk_i) disable iff (reset_i) $countones(~ss_n_o) <= 1;
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("more than one slave selected"); // [RULE15]
  property p_eight;
    @(posedge mclk_i) disable iff (reset_i) done_o |-> $past(bits_r) == 4'h7;
  endproperty
  a_eight: assert property (p_eight) else $error("byte not eight bits"); // [RULE11]
  property p_trail_clk;
    @(posedge mclk_i) disable iff (reset_i)
      (state_r == SMT_TRAIL) |=> (sclk_o != cfg_r.cpol);
  endproperty
  a_trail_clk: assert property (p_trail_clk) else $error("sclk not toggled"); // [RULE2]
  property p_rate;
    @(posedge mclk_i) disable iff (reset_i) tick |=> !tick [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("sclk too fast"); // [RULE14]
  property p_end;
    @(posedge mclk_i) disable iff (reset_i)
      $fell(busy_o) |-> (state_r == SMT_IDLE) ##1 (ss_n_o == SEL_IDLE);
  endproperty
  a_end: assert property (p_end) else $error("select held after end"); // [RULE13]
  property p_busy;
    @(posedge mclk_i) disable iff (reset_i) (state_r == SMT_LEAD) |-> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low during bit"); // [RULE4]
  c_byte: cover property (@(posedge mclk_i) disable iff (reset_i) done_o);
  c_chain: cover property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == SMT_GAP) ##1 (state_r == SMT_LEAD));
  c_mode3: cover property (@(posedge mclk_i) disable iff (reset_i)
    done_o && cfg_r.cpol && cfg_r.cpha);
endmodule
`default_nettype wire

// [smt_master_tb.sv]
// self-checking bench for the spi master against a slave model
`timescale 1ns/10ps
`default_nettype none
module smt_master_tb;
  import smt_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, start = 1'b0, last = 1'b0, gap = 1'b0;
  logic [7:0] tx = 8'h00, reply = 8'h00;
  smt_cfg_s cfg = '0;
  logic busy, done, sclk, mosi, miso;
  logic [7:0] rx, got;
  logic [3:0] ss_n;
  int num_errors = 0, samples_checked = 0;
  smt_master u_smt_master (.mclk_i(mclk), .reset_i(reset), .start_i(start), .last_i(last),
    .gap_i(gap), .tx_byte_i(tx), .cfg_i(cfg), .busy_o(busy), .done_o(done), .rx_byte_o(rx),
    .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso), .ss_n_o(ss_n));
  smt_slave_model u_smt_slave_model (.sclk_i(sclk), .ss_n_i(ss_n[cfg.slave]), .mosi_i(mosi),
    .miso_o(miso), .cpol_i(cfg.cpol), .cpha_i(cfg.cpha), .lsb_i(cfg.lsb_first),
    .reply_i(reply), .got_o(got));
  // 250 MHz system clock
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one byte; when the frame ends also waits for idle
  task automatic xfer(input logic [7:0] d, input logic [7:0] r, input logic l, input logic g);
    int k;
    int h;
    h = (cfg.half_div < HALF_MIN_CYC) ? HALF_MIN_CYC : int'(cfg.half_div);
    tx = d;
    reply = r;
    last = l;
    gap = g;
    start = 1'b1;
    k = 0;
    do begin
      @(negedge mclk);
      // one edge with start high is enough: idle or a waiting chain takes it
      start = 1'b0;
      k++;
    end while (done !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      num_errors++;
      results();
    end
    chk(8'(k >= 16*h && k <= 16*h+8), 8'h01);
    chk({4'h0, ss_n}, {4'h0, ~(4'h1 << cfg.slave)});
    chk(rx, r);
    // the last trailing edge comes one cycle after done
    @(negedge mclk);
    chk(got, d);
    if (l || g) begin
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
        @(negedge mclk);
        k++;
      end
      if (k >= 5000) begin
        num_errors++;
        results();
      end
      @(negedge mclk);
      chk({4'h0, ss_n}, 8'h0f);
      chk({7'h0, sclk}, {7'h0, cfg.cpol});
    end
  endtask
  // every mode on its own slave line
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      cfg = {m[1], m[0], 1'b0, m[1:0], 16'h001e};
      xfer(8'ha5 ^ 8'(m), 8'h3c + 8'(m), 1'b1, 1'b0);
    end
    $display("test modes done");
  endtask
  // lsb first, divider below the floor
  task automatic t_lsb();
    cfg = {1'b0, 1'b1, 1'b1, 2'h1, 16'h0002};
    xfer(8'h1e, 8'hc2, 1'b1, 1'b0);
    $display("test lsb done");
  endtask
  // back to back bytes in one frame
  task automatic t_chain();
    cfg = {1'b1, 1'b1, 1'b0, 2'h2, 16'h0019};
    xfer(8'h12, 8'h96, 1'b0, 1'b0);
    xfer(8'h00, 8'h96, 1'b0, 1'b0);
    xfer(8'hff, 8'h96, 1'b1, 1'b0);
    $display("test chain done");
  endtask
  // byte ended by a short deselect
  task automatic t_gap();
    cfg = {1'b0, 1'b0, 1'b0, 2'h3, 16'h0020};
    xfer(8'h00, 8'hff, 1'b0, 1'b1);
    $display("test gap done");
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_modes();
    t_lsb();
    t_chain();
    t_gap();
    results();
  end
endmodule
`default_nettype wire

// [smt_pkg.sv]
// shared constants and carrier types for the spi master
package smt_pkg;
  // system clock rate in MHz
  localparam int SYS_CLK_MHZ = 250;
  // fastest serial clock allowed
  localparam int SCLK_MAX_MHZ = 5;
  // least half period in system clocks, rounded up
  localparam int HALF_MIN_CYC = (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  // bits in one byte
  localparam int BYTE_BITS = 8;
  // number of slave select lines
  localparam int NUM_SLAVES = 4;
  // divider width
  localparam int DIV_W = 16;
  // reset values
  localparam logic [NUM_SLAVES-1:0] SEL_IDLE = 4'hf;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] BITCNT_RST = 4'h0;
  // transfer engine states, gray along idle-lead-trail-gap
  typedef enum logic [1:0] {
    SMT_IDLE = 2'b00,
    SMT_LEAD = 2'b01,
    SMT_TRAIL = 2'b11,
    SMT_GAP = 2'b10
  } smt_state_e;
  // per-transfer configuration
  typedef struct packed {
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic [1:0] slave;
    logic [DIV_W-1:0] half_div;
  } smt_cfg_s;
endpackage

// [smt_slave_model.sv]
// behavioural spi slave that answers the master in every mode
`timescale 1ns/10ps
`default_nettype none
module smt_slave_model (
  // spi pins
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // mode and data
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic [7:0] reply_i,
  output logic [7:0] got_o
);
  int n; // bit index within the frame
  // bit of the reply for index i, wraps per byte
  function automatic logic pick(input int i);
    return lsb_i ? reply_i[i%8] : reply_i[7-(i%8)];
  endfunction
  // received byte after one more mosi bit
  function automatic logic [7:0] shin();
    return lsb_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
  endfunction
  initial begin
    miso_o = 1'b1;
    got_o = 8'h00;
    n = 0;
  end
  // in phase zero the first bit is shown as soon as selected
  always @(negedge ss_n_i) begin
    n = 0;
    if (!cpha_i) miso_o = pick(0);
  end
  // released line flips so a stale bit cannot pass
  always @(posedge ss_n_i) miso_o = ~miso_o;
  // act on lead or trail edge
  always @(sclk_i) begin
    if (!ss_n_i && (sclk_i != cpol_i) && cpha_i) miso_o = pick(n);
    else if (!ss_n_i && (sclk_i != cpol_i)) got_o = shin();
    else if (!ss_n_i && cpha_i) begin
      got_o = shin();
      n++;
    end else if (!ss_n_i) begin
      n++;
      miso_o = pick(n);
    end
  end
endmodule
`default_nettype wire

// [smt_tick.sv]
// clock-enable divider producing half-period ticks
`timescale 1ns/10ps
`default_nettype none
module smt_tick
  import smt_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  input wire logic run_i,
  input wire logic [DIV_W-1:0] half_div_i,
  // tick out
  output logic tick_o
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] lim;
  // never faster than the bus limit allows
  // [RULE14] half period floor
  always_comb begin
    lim = (half_div_i < DIV_W'(HALF_MIN_CYC)) ? DIV_W'(HALF_MIN_CYC) : half_div_i;
  end
  // counter restarts whenever the engine is stopped
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= lim - DIV_W'(1)) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + DIV_W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire
